/* hw/gpcog_top.sv */
// general-purpose clock output generator with apb registers
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module gpcog_top (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire gpcog_pkg::gpcog_apb_req_t i_apb,
   input wire logic [gpcog_pkg::NSRC-1:0] i_aux_clk,
   output var gpcog_pkg::gpcog_apb_rsp_t o_apb,
   output var logic o_clk_out
);
   import gpcog_pkg::*;

   logic [1:0] rst_s_r;
   logic rst_n;
   gpcog_apb_rsp_t rsp_r;
   logic access;
   logic done;
   logic wr;
   logic hit;
   logic [DW-1:0] rd_data;
   logic [DW-1:0] div1_r;
   logic [DW-1:0] div2_r;
   logic [DW-1:0] ctrl2_r;
   gpcog_ctrl_t ctrl2;
   logic [AUX_W-1:0] aux;
   logic [NSRC-1:0] src_sync;
   logic src_r;
   logic clk_out;

   // ****************************************
   // reset release
   // ****************************************
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         rst_s_r <= 2'h0;
      end
      else
      begin
         rst_s_r <= {rst_s_r[0], 1'b1};
      end
   end

   assign rst_n = rst_s_r[1];

   // ****************************************
   // apb slave
   // ****************************************
   assign access = i_apb.psel & i_apb.penable;
   assign done = access & rsp_r.pready;
   assign wr = done & i_apb.pwrite & hit;
   assign o_apb = rsp_r;

   // read decode, also flags unmapped addresses
   always_comb
   begin
      rd_data = '0;
      hit = 1'b1;
      case (i_apb.paddr)
         OFS_DIV1:
         begin
            rd_data = div1_r;
         end
         OFS_SEL1, OFS_SEL2:
         begin
            rd_data = SEL_RST;
         end
         OFS_CTRL2:
         begin
            rd_data = ctrl2_r;
         end
         OFS_DIV2:
         begin
            rd_data = div2_r;
         end
         default:
         begin
            hit = 1'b0;
         end
      endcase
   end

   // one wait state; answer leaves registered
   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rsp_r <= '0;
      end
      else
      begin
         rsp_r.pready <= access & ~rsp_r.pready;
         if (access && !rsp_r.pready)
         begin
            rsp_r.prdata <= i_apb.pwrite ? '0 : rd_data;
            rsp_r.pslverr <= ~hit;
         end
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div1_r <= DIV_RST;
      end
      else if (wr && i_apb.paddr == OFS_DIV1)
      begin
         div1_r <= i_apb.pwdata;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div2_r <= DIV_RST;
      end
      else if (wr && i_apb.paddr == OFS_DIV2)
      begin
         div2_r <= i_apb.pwdata;
      end
   end

   // reserved bits and the absent primary field stay zero
   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl2_r <= CTRL_RST;
      end
      else if (wr && i_apb.paddr == OFS_CTRL2)
      begin
         ctrl2_r <= i_apb.pwdata & CTRL_WMASK;
      end
   end

   assign ctrl2.phase_a = ctrl2_r[CTRL_PHA_BIT];
   assign ctrl2.start_phase = ctrl2_r[CTRL_PHASE_LSB +: 2];
   assign ctrl2.duty_correction = ctrl2_r[CTRL_DUTY_BIT];
   assign ctrl2.enable = ctrl2_r[CTRL_EN_BIT];
   assign ctrl2.kill = ctrl2_r[CTRL_KILL_BIT];
   assign aux = ctrl2_r[CTRL_AUX_LSB +: AUX_W];

   // ****************************************
   // source selection
   // ****************************************
   gpcog_sync #(
      .W(NSRC)
   ) u_sync (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .i_d(i_aux_clk),
      .o_q(src_sync)
   );

   // plain mux: switching while running may glitch the output
   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         src_r <= 1'b0;
      end
      else if (aux <= AUX_REF_CLK)
      begin
         src_r <= src_sync[aux];
      end
      else
      begin
         src_r <= 1'b0;
      end
   end

   // ****************************************
   // divider
   // ****************************************
   gpcog_divider u_div (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .i_src(src_r),
      .i_ctrl(ctrl2),
      .i_int(div2_r[DIV_INT_LSB +: INT_W]),
      .i_fractional_part(div2_r[FRACTIONAL_PART_W-1:0]),
      .o_clk(clk_out)
   );

   assign o_clk_out = clk_out;

   // ****************************************
   // checks
   // ****************************************
   AST_STATUS: assert property (@(posedge i_clk) disable iff (!rst_n)
      done && !i_apb.pwrite && (i_apb.paddr == OFS_SEL1 || i_apb.paddr == OFS_SEL2)
      |-> rsp_r.prdata == 32'h0000_0001 && !rsp_r.pslverr)
      else $error("source status did not read one");

   AST_STATUS_RO: assert property (@(posedge i_clk) disable iff (!rst_n)
      wr && i_apb.paddr == OFS_SEL2 |=> ctrl2_r == $past(ctrl2_r) && div2_r == $past(div2_r))
      else $error("status write disturbed other registers");

   AST_NO_PRIMARY: assert property (@(posedge i_clk) disable iff (!rst_n)
      done && !i_apb.pwrite && i_apb.paddr == OFS_CTRL2
      |-> rsp_r.prdata[4:0] == 5'h00 && (rsp_r.prdata & ~CTRL_WMASK) == '0)
      else $error("control read shows bits outside its fields");

   AST_DIV_LIVE: assert property (@(posedge i_clk) disable iff (!rst_n)
      wr && i_apb.paddr == OFS_DIV2 |=> div2_r == $past(i_apb.pwdata) && ctrl2_r == $past(ctrl2_r))
      else $error("divisor write while running was not taken");

   AST_DIV1: assert property (@(posedge i_clk) disable iff (!rst_n)
      wr && i_apb.paddr == OFS_DIV1 |=> div1_r[31:8] == $past(i_apb.pwdata[31:8]))
      else $error("integer part not stored in upper bits");

   AST_SEL: assert property (@(posedge i_clk) disable iff (!rst_n)
      aux <= AUX_REF_CLK |=> src_r == $past(src_sync[aux]))
      else $error("selected source does not follow the field");

   AST_SEL_BAD: assert property (@(posedge i_clk) disable iff (!rst_n)
      aux > AUX_REF_CLK |=> !src_r)
      else $error("unused source code not silent");

   AST_WAIT: assert property (@(posedge i_clk) disable iff (!rst_n)
      access && !rsp_r.pready |=> rsp_r.pready ##1 !rsp_r.pready)
      else $error("apb answer not after one wait state");

   AST_UNMAPPED: assert property (@(posedge i_clk) disable iff (!rst_n)
      access && !rsp_r.pready && !hit |=> rsp_r.pready && rsp_r.pslverr)
      else $error("unmapped access not refused");

   AST_KILL_TOP: assert property (@(posedge i_clk) disable iff (!rst_n)
      ctrl2.kill |-> !o_clk_out)
      else $error("kill left the output running");
endmodule
`default_nettype wire

/* hw/gpcog_pkg.sv */
// shared constants and types for the clock output generator
package gpcog_pkg;

   // ****************************************
   // register map
   // ****************************************
   localparam int AW = 12;
   localparam int DW = 32;
   localparam logic [AW-1:0] OFS_DIV1 = 12'h010;
   localparam logic [AW-1:0] OFS_SEL1 = 12'h014;
   localparam logic [AW-1:0] OFS_CTRL2 = 12'h018;
   localparam logic [AW-1:0] OFS_DIV2 = 12'h01c;
   localparam logic [AW-1:0] OFS_SEL2 = 12'h020;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [DW-1:0] CTRL_RST = 32'h0000_0000;
   localparam logic [DW-1:0] DIV_RST = 32'h0000_0100;
   localparam logic [DW-1:0] SEL_RST = 32'h0000_0001;

   // ****************************************
   // field positions
   // ****************************************
   localparam int DIV_INT_LSB = 8;
   localparam int INT_W = 24;
   localparam int FRACTIONAL_PART_W = 8;
   localparam int CTRL_PHA_BIT = 20;
   localparam int CTRL_PHASE_LSB = 16;
   localparam int CTRL_DUTY_BIT = 12;
   localparam int CTRL_EN_BIT = 11;
   localparam int CTRL_KILL_BIT = 10;
   localparam int CTRL_AUX_LSB = 5;
   localparam int AUX_W = 4;
   localparam logic [DW-1:0] CTRL_WMASK = 32'h0013_1de0;

   // ****************************************
   // divider
   // ****************************************
   localparam int NSRC = 11;
   localparam int PER_W = 25;
   localparam logic [PER_W-1:0] ZERO_INT_DIV = 25'h001_0000;
   localparam logic [PER_W-1:0] PER_RST = 25'h000_0001;

   typedef enum logic [AUX_W-1:0] {
      AUX_SYS_PLL = 4'h0,
      AUX_INPUT_PIN_SOURCE_A = 4'h1,
      AUX_INPUT_PIN_SOURCE_B = 4'h2,
      AUX_USB_PLL = 4'h3,
      AUX_RING_OSCILLATOR_PHASED = 4'h4,
      AUX_XTAL_OSC = 4'h5,
      AUX_SYS_CLK = 4'h6,
      AUX_USB_CLK = 4'h7,
      AUX_CONV_CLK = 4'h8,
      AUX_CAL_CLK = 4'h9,
      AUX_REF_CLK = 4'ha
   } gpcog_aux_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_RUN = 3'h2,
      ST_STOP = 3'h4
   } gpcog_state_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [AW-1:0] paddr;
      logic [DW-1:0] pwdata;
   } gpcog_apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [DW-1:0] prdata;
   } gpcog_apb_rsp_t;

   typedef struct packed {
      logic phase_a;
      logic [1:0] start_phase;
      logic duty_correction;
      logic enable;
      logic kill;
   } gpcog_ctrl_t;

endpackage

/* hw/gpcog_sync.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module gpcog_sync #(
   parameter int W = 1
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [W-1:0] i_d,
   output var logic [W-1:0] o_q
);
   import gpcog_pkg::*;

   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;

   // a bit changes only once stages two and three agree
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         o_q <= '0;
      end
      else
      begin
         s1_r <= i_d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         o_q <= (s2_r & s3_r) | (o_q & (s2_r | s3_r));
      end
   end
endmodule
`default_nettype wire

/* hw/gpcog_divider.sv */
// integer plus fraction divider with start phase, phase_a and duty correction
`timescale 1ns/1ps
`default_nettype none
module gpcog_divider (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_src,
   input wire gpcog_pkg::gpcog_ctrl_t i_ctrl,
   input wire logic [gpcog_pkg::INT_W-1:0] i_int,
   input wire logic [gpcog_pkg::FRACTIONAL_PART_W-1:0] i_fractional_part,
   output var logic o_clk
);
   import gpcog_pkg::*;

   gpcog_state_t st_r;
   logic src_d_r;
   logic pha_d_r;
   logic pend_r;
   logic out_r;
   logic kill;
   logic [1:0] phase_lat_r;
   logic [2:0] en_sh_r;
   logic en_dly;
   logic rise;
   logic fall;
   logic step;
   logic corr;
   logic last;
   logic carry;
   logic [FRACTIONAL_PART_W-1:0] acc_r;
   logic [FRACTIONAL_PART_W-1:0] acc_nxt;
   logic [PER_W-1:0] per_r;
   logic [PER_W-1:0] cnt_r;
   logic [PER_W-1:0] cnt_nxt;
   logic [PER_W-1:0] half;
   logic [PER_W-1:0] base;
   logic [PER_W-1:0] per_nxt;

   assign kill = i_ctrl.kill;
   assign rise = i_src & ~src_d_r;
   assign fall = ~i_src & src_d_r;
   assign step = rise & ~pend_r;
   assign en_dly = (phase_lat_r == 2'h0) ? i_ctrl.enable : en_sh_r[phase_lat_r - 2'h1];
   assign corr = per_r[0] & (i_ctrl.duty_correction | per_r == PER_RST);
   assign half = {1'b0, per_r[PER_W-1:1]};
   assign last = cnt_r == per_r - PER_RST;
   assign cnt_nxt = cnt_r + PER_RST;
   assign {carry, acc_nxt} = {1'b0, acc_r} + {1'b0, i_fractional_part};
   assign base = (i_int == '0) ? ZERO_INT_DIV : {1'b0, i_int};
   assign per_nxt = base + {{(PER_W-1){1'b0}}, carry};
   assign o_clk = out_r;

   // ****************************************
   // edges, phase_a and start delay
   // ****************************************
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         src_d_r <= 1'b0;
         pha_d_r <= 1'b0;
         pend_r <= 1'b0;
         en_sh_r <= 3'h0;
         phase_lat_r <= 2'h0;
      end
      else
      begin
         src_d_r <= i_src;
         pha_d_r <= i_ctrl.phase_a;
         // a new edge wins over the one being consumed
         pend_r <= (pend_r & ~rise) | (i_ctrl.phase_a ^ pha_d_r);
         if (rise)
         begin
            en_sh_r <= {en_sh_r[1:0], i_ctrl.enable};
         end
         if (!i_ctrl.enable)
         begin
            phase_lat_r <= i_ctrl.start_phase;
         end
      end
   end

   // ****************************************
   // period counter and output
   // ****************************************
   always_ff @(posedge i_clk or negedge i_rst_n or posedge kill)
   begin
      if (!i_rst_n || kill)
      begin
         st_r <= ST_IDLE;
         out_r <= 1'b0;
         cnt_r <= '0;
         per_r <= PER_RST;
         acc_r <= '0;
      end
      else
      begin
         case (st_r)
            ST_IDLE:
            begin
               if (step && en_dly)
               begin
                  st_r <= ST_RUN;
                  per_r <= per_nxt;
                  acc_r <= acc_nxt;
                  cnt_r <= '0;
                  out_r <= 1'b1;
               end
            end
            ST_RUN, ST_STOP:
            begin
               if (step && last)
               begin
                  // new ratio only taken at a period boundary
                  if (st_r == ST_RUN && en_dly)
                  begin
                     per_r <= per_nxt;
                     acc_r <= acc_nxt;
                     cnt_r <= '0;
                     out_r <= 1'b1;
                  end
                  else
                  begin
                     st_r <= ST_IDLE;
                     out_r <= 1'b0;
                  end
               end
               else
               begin
                  if (st_r == ST_RUN && !en_dly)
                  begin
                     st_r <= ST_STOP;
                  end
                  if (step)
                  begin
                     cnt_r <= cnt_nxt;
                  end
                  if ((step && !corr && cnt_nxt == half) || (fall && corr && cnt_r == half))
                  begin
                     out_r <= 1'b0;
                  end
               end
            end
            default:
            begin
               st_r <= ST_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // checks
   // ****************************************
   AST_KILL: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      kill |-> !out_r && st_r == ST_IDLE)
      else $error("output not held low by kill");
   AST_ZERO_INT: assert property (@(posedge i_clk) disable iff (!i_rst_n || kill)
      st_r == ST_IDLE && step && en_dly && i_int == '0 |=> per_r inside {25'h001_0000, 25'h001_0001})
      else $error("zero integer part not taken as 65536");
   AST_FRACTIONAL_PART: assert property (@(posedge i_clk) disable iff (!i_rst_n || kill)
      st_r == ST_IDLE && step && en_dly && i_fractional_part == '0 |=> acc_r == $past(acc_r) && per_r == $past(base))
      else $error("zero fraction changed the period");
   AST_PHASE_A: assert property (@(posedge i_clk) disable iff (!i_rst_n || kill)
      rise && pend_r && st_r != ST_IDLE |=> cnt_r == $past(cnt_r) && st_r == $past(st_r))
      else $error("phase_a did not hold the count");
   AST_PHASE: assert property (@(posedge i_clk) disable iff (!i_rst_n || kill)
      $rose(en_sh_r[2]) && phase_lat_r == 2'h3 && st_r == ST_IDLE |-> !$past(en_sh_r[1], 2) || !rise)
      else $error("start delay tap wrong");
   AST_DUTY: assert property (@(posedge i_clk) disable iff (!i_rst_n || kill)
      $fell(out_r) && $past(corr) && !$past(kill) && $past(st_r) != ST_IDLE
      && !$past(step && last) |-> $past(fall))
      else $error("corrected output did not fall on a source fall");
   AST_START: assert property (@(posedge i_clk) disable iff (!i_rst_n || kill)
      $rose(out_r) |-> cnt_r == '0 && st_r == ST_RUN && $past(rise))
      else $error("output rose outside a period start");
   AST_NO_RUNT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      st_r == ST_IDLE |-> !out_r)
      else $error("output high while idle");
endmodule
`default_nettype wire

/* sim/gpcog_far_model.sv */
// far-side model: free-running source clocks and an output period meter
`timescale 1ns/1ps
`default_nettype none
module gpcog_far_model (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_clk_out,
   output var logic [gpcog_pkg::NSRC-1:0] o_aux_clk,
   output var logic [31:0] o_period,
   output var logic [31:0] o_high,
   output var logic o_rise,
   output var logic [31:0] o_nrise
);
   import gpcog_pkg::*;
   // ****************************************
   // sources and meter
   // ****************************************
   // source n toggles every 4+n cycles, slow enough for the input filter
   int half [NSRC];
   logic [31:0] cnt;
   logic [31:0] hcnt;
   logic prev;
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_aux_clk <= '0;
         half <= '{default: 0};
      end
      else
      begin
         for (int n = 0; n < NSRC; n++)
         begin
            half[n] <= (half[n] == 3 + n) ? 0 : half[n] + 1;
            if (half[n] == 3 + n)
               o_aux_clk[n] <= ~o_aux_clk[n];
         end
      end
   end
   // counts in whole system cycles; sync latency cancels between edges
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         {cnt, hcnt, o_period, o_high, o_nrise} <= '0;
         {prev, o_rise} <= '0;
      end
      else
      begin
         prev <= i_clk_out;
         o_rise <= i_clk_out & ~prev;
         cnt <= (i_clk_out & ~prev) ? 32'h0000_0001 : cnt + 1;
         hcnt <= i_clk_out ? hcnt + 1 : 32'h0000_0000;
         if (i_clk_out & ~prev)
         begin
            o_period <= cnt;
            o_nrise <= o_nrise + 1;
         end
         if (~i_clk_out & prev)
            o_high <= hcnt;
      end
   end
endmodule
`default_nettype wire

/* sim/gpcog_tb_top.sv */
// self-checking bench for the clock output generator
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin err_count++; $display("wrong value at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module gpcog_tb_top;
   import gpcog_pkg::*;
   logic i_clk;
   logic i_arst_n = 1'b0;
   gpcog_apb_req_t req = '0;
   gpcog_apb_rsp_t rsp;
   logic [NSRC-1:0] aux;
   logic clk_out;
   logic rise;
   logic [31:0] period;
   logic [31:0] high;
   logic [31:0] nrise;
   int err_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   int nsum = 1;
   int k = 0;
   int lat;
   logic [31:0] acc;
   logic [31:0] r;
   logic [63:0] e;
   logic [63:0] apb_q[$];
   logic [63:0] clk_q[$];
   gpcog_top u_dut (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_apb(req),
      .i_aux_clk(aux),
      .o_apb(rsp),
      .o_clk_out(clk_out)
   );
   gpcog_far_model u_far (
      .i_clk(i_clk),
      .i_rst_n(i_arst_n),
      .i_clk_out(clk_out),
      .o_aux_clk(aux),
      .o_period(period),
      .o_high(high),
      .o_rise(rise),
      .o_nrise(nrise)
   );
   initial
   begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   // ****************************************
   // tasks
   // ****************************************
   task automatic close_out();
      $display("checks %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // one extra edge after release so a following setup never lands in the same step
   task automatic apb(input logic wr, input logic [AW-1:0] a, input logic [DW-1:0] d);
      req.psel <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite <= wr;
      req.paddr <= a;
      req.pwdata <= d;
      @(posedge i_clk);
      req.penable <= 1'b1;
      do @(posedge i_clk); while (rsp.pready !== 1'b1);
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      @(posedge i_clk);
   endtask
   task automatic rd(input logic [AW-1:0] a, input logic err, input logic [DW-1:0] d);
      apb_q.push_back({31'h0, err, d});
      apb(1'b0, a, '0);
   endtask
   function automatic logic [31:0] ctl(int src, logic en, logic dc, logic [1:0] ph, logic nd);
      ctl = 32'(src) << CTRL_AUX_LSB;
      ctl[CTRL_EN_BIT] = en;
      ctl[CTRL_DUTY_BIT] = dc;
      ctl[CTRL_PHASE_LSB +: 2] = ph;
      ctl[CTRL_PHA_BIT] = nd;
   endfunction
   // figures in half source periods; two settling rises skip a period in change
   task automatic meas(input int n, input int tot, input int hi, input int src,
                       input logic [31:0] nd);
      repeat (2) @(posedge i_clk iff rise);
      nsum = n;
      k = 0;
      acc = '0;
      clk_q.push_back({32'(hi * (4 + src)), 32'(tot * (4 + src))});
      if (nd != '0)
         apb(1'b1, OFS_CTRL2, nd);
      while (clk_q.size() > 0)
         @(posedge i_clk);
   endtask
   // ****************************************
   // result watcher and timeout
   // ****************************************
   always @(negedge i_clk)
   begin
      if (req.psel && req.penable && rsp.pready && !req.pwrite && apb_q.size() > 0)
      begin
         e = apb_q.pop_front();
         `CHK({31'h0, rsp.pslverr, rsp.prdata}, e)
      end
      if (rise && clk_q.size() > 0)
      begin
         acc = acc + period;
         k++;
         if (k == nsum)
         begin
            e = clk_q.pop_front();
            `CHK({high, acc}, e)
         end
      end
   end
   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_count++;
         close_out();
      end
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      r = $urandom(32'h35a6);
      repeat (6) @(posedge i_clk);
      i_arst_n <= 1'b1;
      repeat (4) @(posedge i_clk);
      rd(OFS_DIV1, 1'b0, DIV_RST);
      rd(OFS_SEL1, 1'b0, SEL_RST);
      rd(OFS_CTRL2, 1'b0, CTRL_RST);
      rd(OFS_DIV2, 1'b0, DIV_RST);
      r = $urandom();
      apb(1'b1, OFS_SEL2, r);
      rd(OFS_SEL2, 1'b0, SEL_RST);
      apb(1'b1, OFS_DIV1, r);
      rd(OFS_DIV1, 1'b0, r);
      r = $urandom() & ~(32'h1 << CTRL_EN_BIT);
      apb(1'b1, OFS_CTRL2, r);
      rd(OFS_CTRL2, 1'b0, r & CTRL_WMASK);
      rd(12'h024, 1'b1, '0);
      apb(1'b1, OFS_CTRL2, '0);
      apb(1'b1, OFS_DIV2, 32'h0000_0200);
      for (int n = 0; n < NSRC; n++)
      begin
         apb(1'b1, OFS_CTRL2, ctl(n, 1'b1, 1'b0, 2'h0, 1'b0));
         meas(1, 4, 2, n, '0);
         apb(1'b1, OFS_CTRL2, ctl(n, 1'b0, 1'b0, 2'h0, 1'b0));
         repeat (60) @(posedge i_clk);
      end
      apb(1'b1, OFS_CTRL2, ctl(0, 1'b1, 1'b0, 2'h0, 1'b0));
      r = 3 + $urandom_range(2);
      apb(1'b1, OFS_DIV2, r << DIV_INT_LSB);
      meas(1, 2 * r, 2 * (r / 2), 0, '0);
      apb(1'b1, OFS_DIV2, 32'h0000_0300);
      apb(1'b1, OFS_CTRL2, ctl(0, 1'b1, 1'b1, 2'h0, 1'b0));
      meas(1, 6, 3, 0, '0);
      apb(1'b1, OFS_CTRL2, ctl(0, 1'b1, 1'b0, 2'h0, 1'b0));
      apb(1'b1, OFS_DIV2, 32'h0000_0280);
      meas(2, 10, 2, 0, '0);
      apb(1'b1, OFS_DIV2, 32'h0000_0400);
      meas(2, 18, 4, 0, ctl(0, 1'b1, 1'b0, 2'h0, 1'b1));
      apb(1'b1, OFS_CTRL2, ctl(0, 1'b0, 1'b0, 2'h0, 1'b1));
      repeat (80) @(posedge i_clk);
      `CHK(high, 32'h0000_0010)
      `CHK(clk_out, 1'b0)
      apb(1'b1, OFS_CTRL2, ctl(0, 1'b1, 1'b0, 2'h0, 1'b1) | (32'h1 << CTRL_KILL_BIT));
      `CHK(clk_out, 1'b0)
      r = nrise;
      repeat (100) @(posedge i_clk);
      `CHK(nrise, r)
      apb(1'b1, OFS_CTRL2, '0);
      for (int p = 0; p < 4; p += 3)
      begin
         apb(1'b1, OFS_CTRL2, ctl(0, 1'b0, 1'b0, 2'(p), 1'b0));
         apb(1'b1, OFS_CTRL2, ctl(0, 1'b1, 1'b0, 2'(p), 1'b0));
         lat = 0;
         while (clk_out !== 1'b1 && lat < 200)
         begin
            @(posedge i_clk);
            lat++;
         end
         `CHK(lat >= 8 * p - 2 && lat <= 8 * p + 24, 1'b1)
         apb(1'b1, OFS_CTRL2, '0);
         repeat (40) @(posedge i_clk);
      end
      close_out();
   end
endmodule
`default_nettype wire
